/* File: design/sys_clock_pkg.sv */
package sys_clock_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] WAIT_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;

  // ==========================================================
  // Control register fields
  localparam int SRC_LSB = 0;
  localparam int DIV_LO_BIT = 3;
  localparam int DIV_HI_BIT = 4;
  localparam int DIV8_BIT = 5;
  localparam int PIN_SEL_BIT = 6;
  localparam int LSO_OFF_BIT = 7;
  localparam int HSO_EN_BIT = 8;
  localparam int PSTOP_BIT = 9;
  localparam int OCD_BIT = 10;
  localparam int LCR_BIT = 11;
  localparam int WLP_BIT = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1FFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0021;

  // ==========================================================
  // Wait register and status fields
  localparam int WREQ_BIT = 0;
  localparam int EXIT_LO_BIT = 1;
  localparam int EXIT_HI_BIT = 2;
  localparam int EXIT_OVR_BIT = 3;
  localparam logic [31:0] WAIT_MASK = 32'h0000_000E;
  localparam logic [31:0] WAIT_RESET = 32'h0000_0000;
  localparam int IN_WAIT_BIT = 0;
  localparam int CPU_STOP_BIT = 1;
  localparam int LOW_PWR_BIT = 2;
  localparam int PEND_BIT = 3;
  localparam int ACT_SRC_LSB = 4;
  localparam int ACT_RATIO_LSB = 7;

  // ==========================================================
  // Source, divider, ratio and exit codes
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_LOW_INT = 3'h1;
  localparam logic [2:0] SRC_SUB = 3'h2;
  localparam logic [2:0] SRC_HIGH_INT = 3'h5;
  localparam logic [1:0] DIV_FIELD_1 = 2'h0;
  localparam logic [1:0] DIV_FIELD_2 = 2'h1;
  localparam logic [1:0] DIV_FIELD_4 = 2'h2;
  localparam logic [1:0] DIV_FIELD_16 = 2'h3;
  localparam logic [2:0] RATIO_1 = 3'h0;
  localparam logic [2:0] RATIO_2 = 3'h1;
  localparam logic [2:0] RATIO_4 = 3'h2;
  localparam logic [2:0] RATIO_8 = 3'h3;
  localparam logic [2:0] RATIO_16 = 3'h4;
  localparam logic [1:0] EXIT_KEEP = 2'h0;
  localparam logic [1:0] EXIT_DIV1 = 2'h1;
  localparam logic [1:0] EXIT_DIV8 = 2'h2;
  localparam logic [1:0] EXIT_DIV16 = 2'h3;

  // ==========================================================
  // Oscillator indices and divider width
  localparam int OSC_MAIN = 0;
  localparam int OSC_SUB = 1;
  localparam int OSC_LOW = 2;
  localparam int OSC_HIGH = 3;
  localparam int NUM_OSC = 4;
  localparam int DIV_WIDTH = 5;
  localparam int NUM_PCLK = 5;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WAIT = 2'b10
  } wait_state_e;

  // ==========================================================
  // Shared decoding
  function automatic logic sys_pick(input logic [2:0] src, input logic [3:0] osc);
    case (src)
      SRC_MAIN: sys_pick = osc[OSC_MAIN];
      SRC_SUB: sys_pick = osc[OSC_SUB];
      SRC_LOW_INT: sys_pick = osc[OSC_LOW];
      SRC_HIGH_INT: sys_pick = osc[OSC_HIGH];
      default: sys_pick = 1'b0;
    endcase
  endfunction : sys_pick

  function automatic logic [2:0] ratio_of(input logic force8, input logic [1:0] field);
    if (force8) begin
      ratio_of = RATIO_8;
    end else begin
      case (field)
        DIV_FIELD_1: ratio_of = RATIO_1;
        DIV_FIELD_2: ratio_of = RATIO_2;
        DIV_FIELD_4: ratio_of = RATIO_4;
        default: ratio_of = RATIO_16;
      endcase
    end
  endfunction : ratio_of

  function automatic logic clk_pick(input logic [2:0] ratio, input logic sys,
                                    input logic [4:0] cnt);
    case (ratio)
      RATIO_2: clk_pick = cnt[0];
      RATIO_4: clk_pick = cnt[1];
      RATIO_8: clk_pick = cnt[2];
      RATIO_16: clk_pick = cnt[3];
      default: clk_pick = sys;
    endcase
  endfunction : clk_pick

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : be_merge

endpackage : sys_clock_pkg

/* File: design/signal_sync2.sv */
`timescale 1ns/100ps
module signal_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Two-stage synchroniser per bit
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule : signal_sync2

/* File: design/edge_divider.sv */
`timescale 1ns/100ps
module edge_divider #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Sampled system clock level and divided taps
  input wire logic sys_level,
  output logic [WIDTH-1:0] count_q
);

  logic prev_q;

  // ==========================================================
  // Count rising edges of the sampled system clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      count_q <= '0;
    end else begin
      prev_q <= sys_level;
      if (sys_level && !prev_q) begin
        count_q <= count_q + WIDTH'(1);
      end
    end
  end

endmodule : edge_divider

/* File: design/system_clock_mode_and_wait_control.sv */
// What this block does
// - Main crystal clock is system clock when pin select is 1 and source 000b.
// - Sub crystal clock is system clock when source field holds 010b.
// - High-speed internal clock used when its enable is 1 and source 101b.
// - Low-speed internal clock used when its off bit is 0 and source 001b.
// - CPU divider: 00 none, 01 /2, 10 /4, 11 /16; force bit gives /8.
// - Wait mode stops CPU clock; oscillators keep running.
// - Peripheral stop bit gates all five prescaled clocks during wait.
// - Wait entered by sleep instruction or by writing 1 to wait request.
// - With stop detection enabled, wait does not stop the CPU.
// - I/O ports hold their pre-wait state throughout wait.
// - Wait from low-speed mode with transition enable enters low-power state.
// - Wait left on reset or enabled peripheral interrupt request.
// - Interrupt exit applies exit clock fields, updating force bit and divider.
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module system_clock_mode_and_wait_control #(
  parameter int PORT_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Oscillator sources
  input wire logic main_crystal_clock,
  input wire logic sub_crystal_clock,
  input wire logic low_speed_internal_clock,
  input wire logic high_speed_internal_clock,
  // CPU core events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Generated clocks
  output logic cpu_clk,
  output logic [4:0] periph_clk,
  // I/O port hold
  input wire logic [PORT_WIDTH-1:0] port_in,
  output logic [PORT_WIDTH-1:0] port_out,
  // Mode outputs
  output logic wait_active,
  output logic low_power_active,
  output logic low_speed_osc_off,
  output logic high_speed_osc_enable,
  output logic osc_stop_detect_enable,
  output logic low_current_read_enable
);

  // ==========================================================
  // Parameter check
  generate
    if (PORT_WIDTH < 1 || PORT_WIDTH > 32) begin : g_bad_width
      $error("PORT_WIDTH must be 1 to 32");
    end
  endgenerate

  logic [3:0] osc_sync;
  logic [sys_clock_pkg::DIV_WIDTH-1:0] div_cnt;
  logic [31:0] ctrl_q;
  logic [31:0] wait_q;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  logic [2:0] sel_src_q;
  logic [2:0] sel_ratio_q;
  logic [2:0] req_src;
  logic [2:0] req_src_eff;
  logic [2:0] req_ratio;
  logic [1:0] exit_sel;
  logic [4:0] ptap;
  logic [4:0] pgate_q;
  logic req_ok;
  logic pending;
  logic sys_level;
  logic cand_cur;
  logic cand_new;
  logic cpu_run_q;
  logic cpu_stop;
  logic pstop_wait;
  logic ack;
  logic bus_wr;
  logic wreq_wr;
  logic enter_now;
  logic exit_now;
  sys_clock_pkg::wait_state_e state_q;

  // ==========================================================
  // Source sampling and edge divider
  signal_sync2 #(
    .WIDTH(sys_clock_pkg::NUM_OSC)
  ) u_osc_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({high_speed_internal_clock, low_speed_internal_clock,
               sub_crystal_clock, main_crystal_clock}),
    .sync_out(osc_sync)
  );

  edge_divider #(
    .WIDTH(sys_clock_pkg::DIV_WIDTH)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sys_level(sys_level),
    .count_q(div_cnt)
  );

  // ==========================================================
  // Avalon handshake: one wait cycle per access
  assign ack = (avs_read || avs_write) && avs_waitrequest;
  assign bus_wr = avs_write && !avs_waitrequest;
  assign wreq_wr = bus_wr && (avs_address == sys_clock_pkg::WAIT_OFS) &&
                   avs_byteenable[0] && avs_writedata[sys_clock_pkg::WREQ_BIT];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !ack;
    end
  end

  // Read data loaded at the end of the wait cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ack && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  // Read decode; unmapped reads return zero
  always_comb begin
    if (avs_address == sys_clock_pkg::CTRL_OFS) begin
      rd_mux = ctrl_q;
    end else if (avs_address == sys_clock_pkg::WAIT_OFS) begin
      rd_mux = wait_q;
      rd_mux[sys_clock_pkg::WREQ_BIT] = (state_q == sys_clock_pkg::ST_WAIT);
    end else if (avs_address == sys_clock_pkg::STAT_OFS) begin
      rd_mux = stat_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Status word
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[sys_clock_pkg::IN_WAIT_BIT] = (state_q == sys_clock_pkg::ST_WAIT);
    stat_word[sys_clock_pkg::CPU_STOP_BIT] = !cpu_run_q;
    stat_word[sys_clock_pkg::LOW_PWR_BIT] = low_power_active;
    stat_word[sys_clock_pkg::PEND_BIT] = pending;
    stat_word[sys_clock_pkg::ACT_SRC_LSB +: 3] = sel_src_q;
    stat_word[sys_clock_pkg::ACT_RATIO_LSB +: 3] = sel_ratio_q;
  end

  // ==========================================================
  // Control register; exit update wins over a bus write
  assign exit_sel = wait_q[sys_clock_pkg::EXIT_HI_BIT:sys_clock_pkg::EXIT_LO_BIT];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= sys_clock_pkg::CTRL_RESET;
    end else if (exit_now && exit_sel != sys_clock_pkg::EXIT_KEEP) begin
      ctrl_q[sys_clock_pkg::DIV8_BIT] <= (exit_sel == sys_clock_pkg::EXIT_DIV8);
      if (exit_sel == sys_clock_pkg::EXIT_DIV1) begin
        ctrl_q[sys_clock_pkg::DIV_HI_BIT:sys_clock_pkg::DIV_LO_BIT] <=
          sys_clock_pkg::DIV_FIELD_1;
      end else if (exit_sel == sys_clock_pkg::EXIT_DIV16) begin
        ctrl_q[sys_clock_pkg::DIV_HI_BIT:sys_clock_pkg::DIV_LO_BIT] <=
          sys_clock_pkg::DIV_FIELD_16;
      end
    end else if (bus_wr && avs_address == sys_clock_pkg::CTRL_OFS) begin
      ctrl_q <= sys_clock_pkg::be_merge(ctrl_q, avs_writedata, avs_byteenable) &
                sys_clock_pkg::CTRL_MASK;
    end
  end

  // Wait register exit fields
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= sys_clock_pkg::WAIT_RESET;
    end else if (bus_wr && avs_address == sys_clock_pkg::WAIT_OFS) begin
      wait_q <= sys_clock_pkg::be_merge(wait_q, avs_writedata, avs_byteenable) &
                sys_clock_pkg::WAIT_MASK;
    end
  end

  assign low_speed_osc_off = ctrl_q[sys_clock_pkg::LSO_OFF_BIT];
  assign high_speed_osc_enable = ctrl_q[sys_clock_pkg::HSO_EN_BIT];
  assign osc_stop_detect_enable = ctrl_q[sys_clock_pkg::OCD_BIT];
  assign low_current_read_enable = ctrl_q[sys_clock_pkg::LCR_BIT];

  // ==========================================================
  // Source request qualification
  assign req_src = ctrl_q[sys_clock_pkg::SRC_LSB +: 3];

  always_comb begin
    case (req_src)
      sys_clock_pkg::SRC_MAIN: req_ok = ctrl_q[sys_clock_pkg::PIN_SEL_BIT];
      sys_clock_pkg::SRC_SUB: req_ok = 1'b1;
      sys_clock_pkg::SRC_HIGH_INT: req_ok = ctrl_q[sys_clock_pkg::HSO_EN_BIT];
      sys_clock_pkg::SRC_LOW_INT: req_ok = !ctrl_q[sys_clock_pkg::LSO_OFF_BIT];
      default: req_ok = 1'b0;
    endcase
  end

  assign req_src_eff = req_ok ? req_src : sel_src_q;
  assign req_ratio = sys_clock_pkg::ratio_of(ctrl_q[sys_clock_pkg::DIV8_BIT],
    ctrl_q[sys_clock_pkg::DIV_HI_BIT:sys_clock_pkg::DIV_LO_BIT]);
  assign pending = (req_src_eff != sel_src_q) || (req_ratio != sel_ratio_q);
  assign sys_level = sys_clock_pkg::sys_pick(sel_src_q, osc_sync);
  assign cand_cur = sys_clock_pkg::clk_pick(sel_ratio_q, sys_level, div_cnt);
  assign cand_new = sys_clock_pkg::clk_pick(req_ratio,
    sys_clock_pkg::sys_pick(req_src_eff, osc_sync), div_cnt);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_src_q <= sys_clock_pkg::SRC_LOW_INT;
      sel_ratio_q <= sys_clock_pkg::RATIO_8;
    end else if (pending && !cand_cur && !cand_new) begin
      sel_src_q <= req_src_eff;
      sel_ratio_q <= req_ratio;
    end
  end

  // ==========================================================
  // Wait mode sequencer
  assign enter_now = (state_q == sys_clock_pkg::ST_RUN) && (sleep_exec || wreq_wr);
  assign exit_now = (state_q == sys_clock_pkg::ST_WAIT) && wake_irq;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= sys_clock_pkg::ST_RUN;
    end else begin
      case (state_q)
        sys_clock_pkg::ST_RUN: begin
          if (sleep_exec || wreq_wr) begin
            state_q <= sys_clock_pkg::ST_WAIT;
          end
        end
        sys_clock_pkg::ST_WAIT: begin
          if (wake_irq) begin
            state_q <= sys_clock_pkg::ST_RUN;
          end
        end
        default: state_q <= sys_clock_pkg::ST_RUN;
      endcase
    end
  end

  // One-hot wait bit, straight from its flop
  assign wait_active = state_q[1];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_power_active <= 1'b0;
    end else if (enter_now) begin
      low_power_active <= ctrl_q[sys_clock_pkg::WLP_BIT] &&
        (sel_src_q == sys_clock_pkg::SRC_SUB || sel_src_q == sys_clock_pkg::SRC_LOW_INT);
    end else if (exit_now) begin
      low_power_active <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_out <= '0;
    end else if (state_q != sys_clock_pkg::ST_WAIT) begin
      port_out <= port_in;
    end
  end

  // ==========================================================
  // CPU clock gate, changed only while the clock is low
  // Stop detection keeps CPU running
  assign cpu_stop = (state_q == sys_clock_pkg::ST_WAIT) &&
                    !ctrl_q[sys_clock_pkg::OCD_BIT];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_run_q <= 1'b1;
      cpu_clk <= 1'b0;
    end else begin
      if (!cand_cur) begin
        cpu_run_q <= !cpu_stop;
      end
      cpu_clk <= cand_cur && cpu_run_q;
    end
  end

  assign pstop_wait = (state_q == sys_clock_pkg::ST_WAIT) &&
                      ctrl_q[sys_clock_pkg::PSTOP_BIT];
  assign ptap = {div_cnt[4], div_cnt[2], div_cnt[1], div_cnt[0], sys_level};

  generate
    for (genvar i = 0; i < sys_clock_pkg::NUM_PCLK; i++) begin : g_pclk
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          pgate_q[i] <= 1'b1;
          periph_clk[i] <= 1'b0;
        end else begin
          if (!ptap[i]) begin
            pgate_q[i] <= !pstop_wait;
          end
          periph_clk[i] <= ptap[i] && pgate_q[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_MAIN_NEEDS_PIN: assert property (
    ($changed(sel_src_q) && sel_src_q == sys_clock_pkg::SRC_MAIN) |->
      $past(ctrl_q[sys_clock_pkg::PIN_SEL_BIT]))
    else $error("main crystal selected without pin select");
  AST_SUB_IS_SYS: assert property (
    (sel_src_q == sys_clock_pkg::SRC_SUB) |-> (sys_level == osc_sync[sys_clock_pkg::OSC_SUB]))
    else $error("sub crystal not routed as system clock");
  AST_HIGH_NEEDS_EN: assert property (
    ($changed(sel_src_q) && sel_src_q == sys_clock_pkg::SRC_HIGH_INT) |->
      $past(ctrl_q[sys_clock_pkg::HSO_EN_BIT]))
    else $error("high-speed internal selected while disabled");
  AST_LOW_NEEDS_ON: assert property (
    ($changed(sel_src_q) && sel_src_q == sys_clock_pkg::SRC_LOW_INT) |->
      !$past(ctrl_q[sys_clock_pkg::LSO_OFF_BIT]))
    else $error("low-speed internal selected while off");
  AST_FORCE_DIV8: assert property (
    ($changed(sel_ratio_q) && $past(ctrl_q[sys_clock_pkg::DIV8_BIT])) |->
      sel_ratio_q == sys_clock_pkg::RATIO_8)
    else $error("force bit did not give divide by 8");
  AST_WAIT_STOPS_CPU: assert property (
    (cpu_stop && !cpu_run_q) [*2] |=> !cpu_clk)
    else $error("cpu clock runs in wait");
  AST_PCLK_GATED: assert property (
    (pstop_wait && pgate_q == 5'h00) |=> periph_clk == 5'h00)
    else $error("prescaled clocks run in wait");
  AST_ENTRY: assert property (
    enter_now |=> wait_active)
    else $error("wait not entered");
  AST_OCD_RUNS: assert property (
    (wait_active && ctrl_q[sys_clock_pkg::OCD_BIT] && cpu_run_q) |=> cpu_run_q)
    else $error("cpu stopped with stop detection enabled");
  AST_PORT_HOLD: assert property (
    (wait_active && $past(wait_active)) |-> $stable(port_out))
    else $error("port changed during wait");
  AST_LOW_POWER: assert property (
    $rose(wait_active) |-> low_power_active == ($past(ctrl_q[sys_clock_pkg::WLP_BIT]) &&
      ($past(sel_src_q) == sys_clock_pkg::SRC_SUB ||
       $past(sel_src_q) == sys_clock_pkg::SRC_LOW_INT)))
    else $error("low-power state wrong at wait entry");
  AST_EXIT: assert property (
    exit_now |=> !wait_active ##1 !low_power_active)
    else $error("wait not left on interrupt");
  AST_EXIT_DIV16: assert property (
    (exit_now && exit_sel == sys_clock_pkg::EXIT_DIV16) |=>
      (ctrl_q[sys_clock_pkg::DIV_HI_BIT:sys_clock_pkg::DIV_LO_BIT] == 2'h3 &&
       !ctrl_q[sys_clock_pkg::DIV8_BIT]))
    else $error("exit divider not applied");
  AST_SAFE_GATE: assert property (
    $changed(cpu_run_q) |-> !$past(cand_cur))
    else $error("cpu gate changed while clock high");

  COV_SLEEP_ENTRY: cover property (sleep_exec && !wait_active ##1 wait_active);
  COV_WRITE_ENTRY: cover property (wreq_wr ##1 wait_active);
  COV_IRQ_EXIT: cover property (exit_now ##1 !wait_active);
  COV_SWITCH: cover property ($changed(sel_src_q));

endmodule : system_clock_mode_and_wait_control

/* File: verif/sys_osc_model.sv */
`timescale 1ns/100ps
module sys_osc_model (
  // Oscillator levels
  output logic main_clk,
  output logic sub_clk,
  output logic low_clk,
  output logic high_clk
);
  // ====================
  // Free-running sources, all slower than ref_clk/4
  // Stable from start, never stopped
  initial begin
    main_clk = 1'b0;
    sub_clk = 1'b0;
    low_clk = 1'b0;
    high_clk = 1'b0;
  end
  always #50 main_clk = ~main_clk;
  always #70 sub_clk = ~sub_clk;
  always #110 low_clk = ~low_clk;
  always #90 high_clk = ~high_clk;
endmodule : sys_osc_model

/* File: verif/system_clock_mode_and_wait_control_bench.sv */
`timescale 1ns/100ps
module system_clock_mode_and_wait_control_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic mc, sc, lc, hc, cpu_clk, wait_active, low_power_active, avs_waitrequest;
  logic lso_off, hso_en, ocd_en, lcr_en;
  logic sleep_exec = 1'b0;
  logic wake_irq = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic [4:0] periph_clk;
  logic [7:0] port_in = 8'h00;
  logic [7:0] port_out;
  int fail_count = 0;
  int tests_run = 0;
  int nc, np;

  // ====================
  // Clock and instances
  always #10 ref_clk = ~ref_clk;
  sys_osc_model osc (.main_clk(mc), .sub_clk(sc), .low_clk(lc), .high_clk(hc));
  system_clock_mode_and_wait_control dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .main_crystal_clock(mc), .sub_crystal_clock(sc), .low_speed_internal_clock(lc),
    .high_speed_internal_clock(hc), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_clk(cpu_clk),
    .periph_clk(periph_clk), .port_in(port_in), .port_out(port_out),
    .wait_active(wait_active), .low_power_active(low_power_active),
    .low_speed_osc_off(lso_off), .high_speed_osc_enable(hso_en),
    .osc_stop_detect_enable(ocd_en), .low_current_read_enable(lcr_en));

  // ====================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic settle;
    repeat (4) @(posedge ref_clk);
    do begin
      bus(1'b0, sys_clock_pkg::STAT_OFS, 32'h0);
    end while (rd[sys_clock_pkg::PEND_BIT] !== 1'b0);
  endtask : settle

  task automatic toggles;
    logic pc;
    logic [4:0] pp;
    nc = 0;
    np = 0;
    pc = cpu_clk;
    pp = periph_clk;
    repeat (60) begin
      @(posedge ref_clk);
      if (cpu_clk !== pc) nc++;
      if (periph_clk !== pp) np++;
      pc = cpu_clk;
      pp = periph_clk;
    end
  endtask : toggles

  task automatic wake;
    @(posedge ref_clk);
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    @(posedge ref_clk);
  endtask : wake

  // ====================
  // Scenarios
  task automatic t_regs;
    bus(1'b0, sys_clock_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_reset", rd, sys_clock_pkg::CTRL_RESET);
    bus(1'b0, sys_clock_pkg::WAIT_OFS, 32'h0);
    chk("wait_reset", rd, sys_clock_pkg::WAIT_RESET);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Ratio already set, then low-current read on
    bus(1'b1, sys_clock_pkg::CTRL_OFS, 32'h0000_0DA1);
    bus(1'b0, sys_clock_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_write", rd, 32'h0000_0DA1);
    chk("ctrl_outs", {28'h0, lso_off, hso_en, ocd_en, lcr_en}, 32'hF);
  endtask : t_regs

  task automatic t_modes;
    logic [31:0] base [4] = '{32'h40, 32'h2, 32'h1, 32'h105};
    logic [2:0] src [4] = '{3'h0, 3'h2, 3'h1, 3'h5};
    logic [2:0] rat [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 5; j++) begin
        bus(1'b1, sys_clock_pkg::CTRL_OFS, base[i] | ((j == 4) ? 32'h28 : (j << 3)));
        settle;
        chk("active_mode", {26'h0, rd[9:4]}, {26'h0, rat[j], src[i]});
      end
    end
    bus(1'b1, sys_clock_pkg::CTRL_OFS, 32'h1);
    settle;
    bus(1'b1, sys_clock_pkg::CTRL_OFS, 32'h5);
    settle;
    chk("high_disabled", {29'h0, rd[6:4]}, 32'h1);
  endtask : t_modes

  task automatic t_sleep;
    // Stop detection off, low-speed internal at /8
    bus(1'b1, sys_clock_pkg::CTRL_OFS, 32'h1221);
    settle;
    bus(1'b1, sys_clock_pkg::WAIT_OFS, 32'h2);
    port_in <= 8'hA5;
    @(posedge ref_clk);
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    @(posedge ref_clk);
    chk("wait_entry", wait_active, 1'b1);
    chk("low_power", low_power_active, 1'b1);
    port_in <= 8'h3C;
    // Long enough for the slowest gate to reach a low phase
    repeat (400) @(posedge ref_clk);
    toggles;
    chk("cpu_stopped", nc, 32'h0);
    chk("periph_gated", np, 32'h0);
    chk("port_hold", port_out, 8'hA5);
    wake;
    chk("wait_exit", wait_active, 1'b0);
    chk("low_power_exit", low_power_active, 1'b0);
    bus(1'b0, sys_clock_pkg::CTRL_OFS, 32'h0);
    chk("exit_divider", {29'h0, rd[5:3]}, 32'h0);
  endtask : t_sleep

  task automatic t_ocd;
    // Sub crystal source, so stop detection may stay on
    bus(1'b1, sys_clock_pkg::CTRL_OFS, 32'h402);
    settle;
    // Wait request with exit to divide by 16
    bus(1'b1, sys_clock_pkg::WAIT_OFS, 32'h7);
    @(posedge ref_clk);
    chk("wreq_entry", wait_active, 1'b1);
    bus(1'b0, sys_clock_pkg::WAIT_OFS, 32'h0);
    chk("wreq_read", rd, 32'h7);
    toggles;
    chk("cpu_runs", {31'h0, nc != 0}, 32'h1);
    wake;
    chk("ocd_exit", wait_active, 1'b0);
    bus(1'b0, sys_clock_pkg::CTRL_OFS, 32'h0);
    chk("exit_div16", {29'h0, rd[5:3]}, 32'h3);
  endtask : t_ocd

  // ====================
  // Verdict, main sequence and watchdog
  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_modes;
    t_sleep;
    t_ocd;
    end_sim;
  end

  initial begin
    #2000000;
    fail_count++;
    end_sim;
  end
endmodule : system_clock_mode_and_wait_control_bench
